//--- rtl/sls_map.svh
// register offsets, field positions and reset values of the lane status bank
// assumes inclusion by bare name from design files
`ifndef SLS_MAP_SVH
`define SLS_MAP_SVH
`define SLS_LINK_PAGE_IDX   12'h300
`define SLS_FRAME_IDX       12'h471
`define SLS_SUM_IDX         12'h472
`define SLS_IRQ_STAT_IDX    12'h474
`define SLS_IRQ_MASK_IDX    12'h475
`define SLS_STATUS_RST      8'h00
`define SLS_PAGE_RST        1'b0
`define SLS_PAGE_BIT        0
`define SLS_IRQ_FRAME_LOST  0
`define SLS_IRQ_SUM_BAD     1
`define SLS_IRQ_RST         2'h0
`endif

//--- rtl/sls_pkg.sv
// types shared by the lane status bank
// assumes sls_map.svh holds all numeric constants
package sls_pkg;
  typedef logic [7:0] sls_lane_t;
  typedef enum logic [1:0] {
    SLS_IDLE = 2'b00,
    SLS_DONE = 2'b01
  } sls_bus_e;
endpackage

//--- rtl/sls_status_if.sv
// carries per-link lane status from the tracker to the register bank
// assumes one clock domain
`timescale 1ns/100ps
interface sls_status_if;
  sls_pkg::sls_lane_t frame_r [2];
  sls_pkg::sls_lane_t sum_r [2];
  logic [1:0]         frame_lost;
  logic [1:0]         sum_bad;
  modport src (output frame_r, output sum_r, output frame_lost, output sum_bad);
  modport dst (input frame_r, input sum_r, input frame_lost, input sum_bad);
endinterface

//--- rtl/sls_lane_track.sv
// registers live lane status for each link and flags losses
// assumes lane inputs synchronous to ref_clk
`timescale 1ns/100ps
`include "sls_map.svh"
module sls_lane_track #(
  parameter int LINKS = 2
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       clk_en,
  // live lane state per link
  input wire logic [7:0] frame_align_in [LINKS],
  input wire logic [7:0] sum_ok_in [LINKS],
  // to register bank
  sls_status_if.src      st
);
  for (genvar k = 0; k < LINKS; k++) begin : g_link
    // any bit falling is an event for the interrupt logic
    assign st.frame_lost[k] = clk_en && |(st.frame_r[k] & ~frame_align_in[k]);
    assign st.sum_bad[k]    = clk_en && |(st.sum_r[k] & ~sum_ok_in[k]);
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        st.frame_r[k] <= `SLS_STATUS_RST; // [R2]
        st.sum_r[k]   <= `SLS_STATUS_RST; // [R5] [R6]
      end else if (clk_en) begin
        st.frame_r[k] <= frame_align_in[k]; // [R1] [R7]
        st.sum_r[k]   <= sum_ok_in[k];      // [R4] [R5] [R6] [R7]
      end
    end
  end
endmodule

//--- rtl/sls_regs.sv
// How it works
// (R1) frame sync per lane, bit n lane n
// (R2) frame bits read-only, reset to zero
// (R3) link page selects which link shows
// (R4) checksum-good per lane, bit 7 lane 7
// (R5) lanes 6 and 5 at bits 6, 5
// (R6) lanes 4 to 0 at bits 4..0
// (R7) bits follow live lane state, no clear
// file: Avalon-MM slave for lane status, paging and interrupt
// assumes register index = byte address / 4, inputs synchronous to ref_clk
`timescale 1ns/100ps
`include "sls_map.svh"
module sls_regs #(
  parameter int LINKS = 2
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // lane receivers
  input  wire logic [7:0]  frame_align_in [LINKS],
  input  wire logic [7:0]  sum_ok_in [LINKS],
  // avalon-mm slave
  input  wire logic [13:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic [1:0]       response,
  output logic             waitrequest,
  // interrupt
  output logic             irq
);
  sls_status_if st ();
  sls_pkg::sls_bus_e state_r;
  logic              page_r;
  logic [1:0]        irq_stat_r;
  logic [1:0]        irq_mask_r;
  logic [11:0]       idx;
  logic              acc;
  logic              hit_page, hit_frame, hit_sum, hit_stat, hit_mask, hit_any;
  logic [7:0]        rd_byte;
  logic [1:0]        ev;
  logic              wr_ok;

  sls_lane_track #(.LINKS(LINKS)) u_track (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .clk_en         (clk_en),
    .frame_align_in (frame_align_in),
    .sum_ok_in      (sum_ok_in),
    .st             (st)
  );

  // one wait cycle, answer on the second edge of the request
  assign acc         = (read || write) && state_r == sls_pkg::SLS_IDLE && clk_en;
  assign waitrequest = (read || write) && state_r != sls_pkg::SLS_DONE;
  assign idx         = address[13:2];
  assign hit_page    = idx == `SLS_LINK_PAGE_IDX;
  assign hit_frame   = idx == `SLS_FRAME_IDX;
  assign hit_sum     = idx == `SLS_SUM_IDX;
  assign hit_stat    = idx == `SLS_IRQ_STAT_IDX;
  assign hit_mask    = idx == `SLS_IRQ_MASK_IDX;
  assign hit_any     = hit_page || hit_frame || hit_sum || hit_stat || hit_mask;
  assign wr_ok       = acc && write && byteenable[0];

  // paged view of live status
  assign rd_byte = hit_frame ? st.frame_r[page_r]           // [R1] [R3]
                 : hit_sum   ? st.sum_r[page_r]             // [R4] [R3]
                 : hit_page  ? {7'h00, page_r}
                 : hit_stat  ? {6'h00, irq_stat_r}
                 : hit_mask  ? {6'h00, irq_mask_r}
                 : 8'h00;

  // events from either link set the sticky bits
  assign ev[`SLS_IRQ_FRAME_LOST] = |st.frame_lost;
  assign ev[`SLS_IRQ_SUM_BAD]    = |st.sum_bad;
  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r  <= sls_pkg::SLS_IDLE;
      readdata <= 32'h0000_0000;
      response <= 2'h0;
    end else if (clk_en) begin
      case (state_r)
        sls_pkg::SLS_IDLE: begin
          if (acc) begin
            state_r  <= sls_pkg::SLS_DONE;
            readdata <= {24'h00_0000, rd_byte};
            response <= hit_any ? 2'h0 : 2'h2; // slave error when unmapped
          end
        end
        default: begin
          state_r <= sls_pkg::SLS_IDLE;
        end
      endcase
    end
  end

  // status registers ignore writes; only page, mask and clear are writable
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      page_r     <= `SLS_PAGE_RST;
      irq_mask_r <= `SLS_IRQ_RST;
      irq_stat_r <= `SLS_IRQ_RST;
    end else if (clk_en) begin
      if (wr_ok && hit_page) begin
        page_r <= writedata[`SLS_PAGE_BIT] & (LINKS > 1); // [R3]
      end
      if (wr_ok && hit_mask) begin
        irq_mask_r <= writedata[1:0];
      end
      // a set in the clear cycle wins
      irq_stat_r <= (irq_stat_r & ~((wr_ok && hit_stat) ? writedata[1:0] : 2'h0)) | ev;
    end
  end

  property p_frame_live;
    @(posedge ref_clk) disable iff (reset)
      clk_en |=> st.frame_r[0] == $past(frame_align_in[0]);
  endproperty
  a_frame_live: assert property (p_frame_live) else $error("frame status stale"); // [R1]

  property p_sum_live;
    @(posedge ref_clk) disable iff (reset)
      clk_en |=> st.sum_r[LINKS-1] == $past(sum_ok_in[LINKS-1]);
  endproperty
  a_sum_live: assert property (p_sum_live) else $error("checksum status stale"); // [R4]

  property p_ro_frame;
    @(posedge ref_clk) disable iff (reset)
      (wr_ok && hit_frame && page_r == 1'b0 && frame_align_in[0] == 8'h00) |=>
        st.frame_r[0] == 8'h00;
  endproperty
  a_ro_frame: assert property (p_ro_frame) else $error("frame status written"); // [R2]

  sequence s_rd_req;
    acc && read && (hit_frame || hit_sum);
  endsequence
  property p_page_read;
    @(posedge ref_clk) disable iff (reset)
      s_rd_req |=> readdata[7:0] ==
        ($past(hit_frame) ? $past(st.frame_r[page_r]) : $past(st.sum_r[page_r]));
  endproperty
  a_page_read: assert property (p_page_read) else $error("paged read wrong"); // [R3]

  property p_sum_low_bits;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && sum_ok_in[0][4:0] == 5'h00) |=> st.sum_r[0][4:0] == 5'h00;
  endproperty
  a_sum_low_bits: assert property (p_sum_low_bits) else $error("low lane sum bit"); // [R6]

  property p_sum_mid_bits;
    @(posedge ref_clk) disable iff (reset)
      clk_en |=> st.sum_r[0][6:5] == $past(sum_ok_in[0][6:5]);
  endproperty
  a_sum_mid_bits: assert property (p_sum_mid_bits) else $error("lane 6/5 sum bit"); // [R5]

  property p_drop;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && st.frame_r[0][0] && !frame_align_in[0][0]) |=>
        !st.frame_r[0][0] && irq_stat_r[`SLS_IRQ_FRAME_LOST];
  endproperty
  a_drop: assert property (p_drop) else $error("loss not tracked"); // [R7]

  property p_answer;
    @(posedge ref_clk) disable iff (reset)
      (acc && !write) |=> !waitrequest || !read;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after one wait");

  property p_rst_zero;
    @(posedge ref_clk) $fell(reset) |-> st.frame_r[0] == 8'h00 && st.sum_r[0] == 8'h00;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("status not zero at reset"); // [R2]

  // a frozen clock stalls the bus and never accepts, except in SLS_DONE, where waitrequest stays low
  sequence s_frozen_req;
    !clk_en && (read || write);
  endsequence
  property p_bus_stall;
    @(posedge ref_clk) disable iff (reset)
      s_frozen_req |-> waitrequest;
  endproperty
  a_bus_stall: assert property (p_bus_stall) else $error("answer while frozen");

  property p_freeze;
    @(posedge ref_clk) disable iff (reset)
      !clk_en |=> st.frame_r[0] == $past(st.frame_r[0]) && page_r == $past(page_r)
        && irq_stat_r == $past(irq_stat_r) && state_r == $past(state_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_unmapped;
    @(posedge ref_clk) disable iff (reset)
      (acc && !hit_any) |=> response == 2'h2 && readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  // page bit stuck low with a single link
  property p_page_write;
    @(posedge ref_clk) disable iff (reset)
      (wr_ok && hit_page) |=>
        page_r == ($past(writedata[`SLS_PAGE_BIT]) && (LINKS > 1));
  endproperty
  a_page_write: assert property (p_page_write) else $error("page select not taken"); // [R3]

  property p_mask_write;
    @(posedge ref_clk) disable iff (reset)
      (wr_ok && hit_mask) |=> irq_mask_r == $past(writedata[1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not taken");

  property p_clear;
    @(posedge ref_clk) disable iff (reset)
      (wr_ok && hit_stat && writedata[1:0] == 2'h3 && ev == 2'h0) |=> irq_stat_r == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");

  // sticky until software clears it
  property p_sticky;
    @(posedge ref_clk) disable iff (reset)
      (clk_en && irq_stat_r[`SLS_IRQ_FRAME_LOST] && !(wr_ok && hit_stat && writedata[0])) |=>
        irq_stat_r[`SLS_IRQ_FRAME_LOST];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");
endmodule

//--- testbench/sls_lane_model.sv
// lane receiver stand-in: registers commanded per-link lane state
// assumes bench changes commands just after a rising edge
`timescale 1ns/100ps
module sls_lane_model (
  // clock
  input  wire logic       ref_clk,
  // commanded state
  input  wire logic [7:0] frame_set [2],
  input  wire logic [7:0] sum_set [2],
  // live lane state
  output logic [7:0]      frame_align_out [2],
  output logic [7:0]      sum_ok_out [2]
);
  // one register stage, like a real receiver flag
  always_ff @(posedge ref_clk) begin
    frame_align_out <= frame_set;
    sum_ok_out      <= sum_set;
  end
endmodule

//--- testbench/sls_regs_tb.sv
// bench for the lane status register bank
// assumes one wait cycle per access, index = byte address / 4
`timescale 1ns/100ps
module sls_regs_tb;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [13:0] address = 14'h0000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic [1:0]  response;
  logic        waitrequest;
  logic        irq;
  logic        clk_en = 1'b1;
  logic [7:0]  f_set [2];
  logic [7:0]  s_set [2];
  logic [7:0]  f_ln [2];
  logic [7:0]  s_ln [2];
  logic [31:0] rd;
  logic [1:0]  rs;
  int          fail_count = 0;
  int          checks = 0;
  sls_lane_model sls_lane_model_i (.ref_clk(ref_clk), .frame_set(f_set), .sum_set(s_set),
    .frame_align_out(f_ln), .sum_ok_out(s_ln));
  sls_regs #(.LINKS(2)) sls_regs_i (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .frame_align_in(f_ln), .sum_ok_in(s_ln), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .response(response), .waitrequest(waitrequest), .irq(irq));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // idle edge first, so a release and a new request never share a time step
  task automatic acc(input logic we, input logic [11:0] ix, input logic [7:0] wd);
    int   n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge ref_clk);
    address   <= {ix, 2'b00};
    write     <= we;
    read      <= ~we;
    writedata <= {24'h000000, wd};
    while (n < 50 && !ok) begin
      #1;
      ok = (waitrequest === 1'b0);
      @(posedge ref_clk);
      n++;
    end
    read  <= 1'b0;
    write <= 1'b0;
    rd = readdata;
    rs = response;
    if (!ok) begin
      fail_count++;
      end_of_test;
    end
  endtask
  task automatic rchk(input string nm, input logic [11:0] ix, input logic [7:0] ex);
    acc(1'b0, ix, 8'h00);
    chk(nm, {24'h000000, ex}, rd);
  endtask
  // model stage plus status stage: three edges cover it
  task automatic lanes(input logic [7:0] f0, s0, f1, s1);
    @(posedge ref_clk);
    f_set <= '{f0, f1};
    s_set <= '{s0, s1};
    repeat (3) @(posedge ref_clk);
  endtask
  initial begin
    f_set = '{8'h00, 8'h00};
    s_set = '{8'h00, 8'h00};
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rchk("frame reset", 12'h471, 8'h00);
    rchk("sum reset", 12'h472, 8'h00);
    acc(1'b1, 12'h471, 8'h5A);
    rchk("frame ro", 12'h471, 8'h00);
    lanes(8'hA5, 8'h3C, 8'h5A, 8'hC3);
    acc(1'b1, 12'h471, 8'hFF);
    acc(1'b1, 12'h472, 8'hFF);
    rchk("frame link0", 12'h471, 8'hA5);
    rchk("sum link0", 12'h472, 8'h3C);
    acc(1'b1, 12'h300, 8'h01);
    rchk("page", 12'h300, 8'h01);
    rchk("frame link1", 12'h471, 8'h5A);
    rchk("sum link1", 12'h472, 8'hC3);
    acc(1'b1, 12'h300, 8'h00);
    rchk("frame back0", 12'h471, 8'hA5);
    for (int n = 0; n < 8; n++) begin
      lanes(8'h01 << n, 8'h80 >> n, 8'h00, 8'h00);
      rchk("frame lane", 12'h471, 8'h01 << n);
      rchk("sum lane", 12'h472, 8'h80 >> n);
    end
    // enable low: lanes move, status and bus must hold
    @(posedge ref_clk);
    clk_en <= 1'b0;
    lanes(8'hFF, 8'h01, 8'h00, 8'h00);
    fork
      rchk("frozen frame", 12'h471, 8'h80);
      begin
        repeat (5) @(posedge ref_clk);
        #1;
        chk("frozen wait", 32'h1, {31'h0, waitrequest});
        @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    join
    rchk("thawed frame", 12'h471, 8'hFF);
    lanes(8'h00, 8'h00, 8'h00, 8'h00);
    rchk("frame lost", 12'h471, 8'h00);
    rchk("sum lost", 12'h472, 8'h00);
    rchk("irq status set", 12'h474, 8'h03);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    acc(1'b1, 12'h475, 8'h03);
    #1;
    chk("irq unmasked", 32'h1, {31'h0, irq});
    acc(1'b1, 12'h474, 8'h03);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    rchk("irq status", 12'h474, 8'h00);
    rchk("unmapped data", 12'h476, 8'h00);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    end_of_test;
  end
endmodule
